/* File: hdl/gsr_pkg.sv */
// constants for the gauge status readback block
package gsr_pkg;
    localparam int WORD_W = 16;
    localparam int ACC_W = 15;
    // enable/configuration command data field positions
    localparam int SEL_HI_POS = 11;
    localparam int SEL_LO_POS = 10;
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
    // device status word bit positions
    localparam int DS_GAUGE1_DIRECTION = 15;
    localparam int DS_GAUGE0_DIRECTION = 14;
    localparam int DS_ZSIDE1 = 13;
    localparam int DS_ZSIDE0 = 12;
    localparam int DS_OFFT1 = 11;
    localparam int DS_OFFT0 = 10;
    localparam int DS_HIGH = 9;
    localparam int DS_LOW = 8;
    localparam int DS_CAL = 7;
    localparam int DS_RANGE = 6;
    localparam int DS_GAUGE1_MOVED = 5;
    localparam int DS_GAUGE0_MOVED = 4;
    localparam int DS_HOME1 = 3;
    localparam int DS_HOME0 = 2;
    localparam int DS_HOT1 = 1;
    localparam int DS_HOT0 = 0;
    // accumulator status word layout
    localparam int AS_HOMING = 15;
    localparam logic [ACC_W-1:0] ACC_RESET = 15'h0000;
    // link timing
    localparam real CLK_PERIOD_NS = 40.0;
    localparam int SYNC_STAGES = 3;
    localparam logic [4:0] BIT_CNT_W1 = 5'h0F;
    typedef enum logic [2:0] {
        GSR_IDLE = 3'b001,
        GSR_SHIFT = 3'b010,
        GSR_DONE = 3'b100
    } gsr_state_e;
endpackage

/* File: hdl/gsr_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gsr_sync #(
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } gsr_sync_s;
    gsr_sync_s q;
    gsr_sync_s next_q;

    always_comb begin
        next_q = q;
        next_q.stage = {q.stage[1:0], pin_in};
        // stage 0 feeds only stage 1; change counts once 1 and 2 agree
        if (q.stage[1] == q.stage[2]) begin
            next_q.level = q.stage[2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= '{stage: {3{INIT}}, level: INIT};
        end else begin
            q <= next_q;
        end
    end

    assign level_out = q.level;
endmodule
`default_nettype wire

/* File: hdl/gsr_event_latch.sv */
// sticky event flag, cleared on request; a coincident set wins
`timescale 1ns/1ps
`default_nettype none
module gsr_event_latch #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // events and clear
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flag_out
);
    typedef struct packed {
        logic [W-1:0] flag;
    } gsr_latch_s;
    gsr_latch_s q;
    gsr_latch_s next_q;

    always_comb begin
        next_q.flag = (q.flag & ~clr_in) | set_in;
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign flag_out = q.flag;
endmodule
`default_nettype wire

/* File: hdl/gsr_readback.sv */
// status readback: selector, device status word, accumulator status word, serial shifter
// How it works
// - status selection holds until a valid command rewrites it or reset
// - select bit 11 low picks the device status word
// - select bits 11,10 = 1,0 picks the accumulator status word
// - bits 15,14 give gauge 1 and gauge 0 direction
// - bits 13,12 give gauge 1 and gauge 0 zero side
// - bits 11,10 high while a gauge is off its commanded target
// - bit 9 latches overvoltage since last frame; coil outputs disabled
// - bit 8 latches undervoltage since last frame; no disable
// - bit 7 shows clock calibration out of tolerance
// - bit 6 set if under or overvoltage since last frame
// - bits 5,4 set if gauge position changed since last frame
// - bits 3,2 homing; hold until frame after zero found or homing off
// - bits 1,0 overtemperature; gauge disabled; hold until gauge re-enabled
// - accumulator word bit 15 homing active, same clearing as per-gauge bits
// - bits 14..0 carry integrator; zero at reset, hold after homing
// - integrator bit 14 is the two's-complement sign used for zero detect
// - status word is read-only; shifted-in data never alters it
// - chip select fall loads selected word, sent msb first
// - chip select rise accepts frame only if length, saturated at MAX_FRAME_BITS, is a nonzero multiple of 16
// - supply fault flags stay until sent in a valid frame; resent otherwise
`timescale 1ns/1ps
`default_nettype none
module gsr_readback
    import gsr_pkg::*;
#(
    parameter int MAX_FRAME_BITS = 1024
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // serial link pins
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // decoded frame hand-off to command logic
    output logic frame_valid_out,
    output logic [WORD_W-1:0] frame_word_out,
    // configuration command strobe from command decode
    input wire logic cfg_write_in,
    input wire logic [WORD_W-1:0] cfg_data_in,
    input wire logic [1:0] gauge_enable_in,
    // gauge state from motor logic
    input wire logic [1:0] gauge_direction_in,
    input wire logic [1:0] gauge_zero_side_in,
    input wire logic [1:0] gauge_off_target_in,
    input wire logic [1:0] gauge_step_in,
    input wire logic [1:0] gauge_homing_req_in,
    input wire logic [1:0] gauge_zero_found_in,
    input wire logic [ACC_W-1:0] stall_integrator_in,
    input wire logic stall_integrator_load_in,
    // fault detectors
    input wire logic supply_high_in,
    input wire logic supply_low_in,
    input wire logic clock_cal_bad_in,
    input wire logic [1:0] gauge_hot_in,
    // protective disables
    output logic coil_disable_out,
    output logic [1:0] gauge_disable_out,
    // selected status view
    output logic [SEL_W-1:0] status_select_field_out
);
    localparam int CNT_W = $clog2(MAX_FRAME_BITS + 1);

    typedef struct packed {
        gsr_state_e state;
        logic cs_d;
        logic sclk_d;
        logic [WORD_W-1:0] shift_out;
        logic [WORD_W-1:0] shift_in;
        logic [CNT_W-1:0] bit_cnt;
        logic sent_dev;
        logic [SEL_W-1:0] sel;
        logic [1:0] homing;
        logic [1:0] zero_seen;
        logic [1:0] hot;
        logic [ACC_W-1:0] acc;
        logic sdo;
        logic sdo_oe;
        logic frame_valid;
        logic [WORD_W-1:0] frame_word;
        logic coil_dis;
        logic [1:0] gauge_dis;
        logic [1:0] en_d;
    } gsr_core_s;
    gsr_core_s q;
    gsr_core_s next_q;

    logic cs_n;
    logic sclk;
    logic sdi;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic [3:0] ev_flag;
    logic frame_ok_dev;

    gsr_sync #(.INIT(1'b1)) u_cs (
        .clk_in(clk_in), .rstn_in(rstn_in), .pin_in(cs_n_in), .level_out(cs_n));
    gsr_sync #(.INIT(1'b0)) u_sclk (
        .clk_in(clk_in), .rstn_in(rstn_in), .pin_in(sclk_in), .level_out(sclk));
    gsr_sync #(.INIT(1'b0)) u_sdi (
        .clk_in(clk_in), .rstn_in(rstn_in), .pin_in(sdi_in), .level_out(sdi));

    // flags: [3] overvoltage, [2] undervoltage, [1] gauge1 moved, [0] gauge0 moved
    assign ev_set = {supply_high_in, supply_low_in, gauge_step_in};
    assign ev_clr = {4{frame_ok_dev}};

    gsr_event_latch #(.W(4)) u_events (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .flag_out(ev_flag)
    );

    // length check: nonzero and a whole number of words
    function automatic logic len_ok(input logic [CNT_W-1:0] n);
        len_ok = (n != '0) && (n[3:0] == 4'h0);
    endfunction

    function automatic logic [WORD_W-1:0] dev_word(input gsr_core_s s, input logic [3:0] f);
        logic [WORD_W-1:0] w;
        w = '0;
        w[DS_GAUGE1_DIRECTION] = gauge_direction_in[1];
        w[DS_GAUGE0_DIRECTION] = gauge_direction_in[0];
        w[DS_ZSIDE1] = gauge_zero_side_in[1];
        w[DS_ZSIDE0] = gauge_zero_side_in[0];
        w[DS_OFFT1] = gauge_off_target_in[1];
        w[DS_OFFT0] = gauge_off_target_in[0];
        w[DS_HIGH] = f[3];
        w[DS_LOW] = f[2];
        w[DS_CAL] = clock_cal_bad_in;
        w[DS_RANGE] = f[3] | f[2];
        w[DS_GAUGE1_MOVED] = f[1];
        w[DS_GAUGE0_MOVED] = f[0];
        w[DS_HOME1] = s.homing[1];
        w[DS_HOME0] = s.homing[0];
        w[DS_HOT1] = s.hot[1];
        w[DS_HOT0] = s.hot[0];
        dev_word = w;
    endfunction

    always_comb begin
        next_q = q;
        next_q.cs_d = cs_n;
        next_q.sclk_d = sclk;
        next_q.en_d = gauge_enable_in;
        next_q.frame_valid = 1'b0;
        frame_ok_dev = 1'b0;

        // selection changes only on a valid configuration write
        if (cfg_write_in) begin
            next_q.sel = cfg_data_in[SEL_HI_POS:SEL_HI_POS-SEL_W+1];
        end

        // homing: request starts it; frame after zero found or request drop ends it
        for (int g = 0; g < 2; g++) begin
            if (!gauge_homing_req_in[g]) begin
                next_q.homing[g] = 1'b0;
                next_q.zero_seen[g] = 1'b0;
            end else if (!q.homing[g] && !q.zero_seen[g]) begin
                next_q.homing[g] = 1'b1;
            end
            if (gauge_zero_found_in[g] && q.homing[g]) begin
                next_q.zero_seen[g] = 1'b1;
            end
            // overtemperature holds the gauge off until it is enabled again;
            // only a fresh enable counts, a standing enable level would undo it at once
            if (gauge_hot_in[g]) begin
                next_q.hot[g] = 1'b1;
                next_q.gauge_dis[g] = 1'b1;
            end else if (gauge_enable_in[g] && !q.en_d[g]) begin
                next_q.hot[g] = 1'b0;
                next_q.gauge_dis[g] = 1'b0;
            end
        end

        // overvoltage cuts the coils until the overvoltage flag is clear and a fresh enable leaves both gauges enabled
        if (supply_high_in) begin
            next_q.coil_dis = 1'b1;
        end else if (&gauge_enable_in && (|(gauge_enable_in & ~q.en_d)) && !ev_flag[3]) begin
            next_q.coil_dis = 1'b0;
        end

        // integrator keeps its last result once homing stops
        if (stall_integrator_load_in && (|q.homing)) begin
            next_q.acc = stall_integrator_in;
        end

        case (q.state)
            GSR_IDLE: begin
                next_q.sdo_oe = 1'b0;
                if (q.cs_d && !cs_n) begin
                    // load the selected word; shift register is separate from status
                    if (!q.sel[SEL_W-1]) begin
                        next_q.shift_out = dev_word(q, ev_flag);
                        next_q.sent_dev = 1'b1;
                    end else if (!q.sel[SEL_W-2]) begin
                        next_q.shift_out = {(|q.homing), q.acc};
                        next_q.sent_dev = 1'b0;
                    end else begin
                        // position and velocity words are supplied elsewhere
                        next_q.shift_out = '0;
                        next_q.sent_dev = 1'b0;
                    end
                    next_q.sdo = next_q.shift_out[WORD_W-1];
                    next_q.sdo_oe = 1'b1;
                    next_q.bit_cnt = '0;
                    next_q.state = GSR_SHIFT;
                end
            end
            GSR_SHIFT: begin
                if (!q.sclk_d && sclk) begin
                    // input bits refill the chain; status flags are never written
                    next_q.shift_in = {q.shift_in[WORD_W-2:0], sdi};
                    if (q.bit_cnt != CNT_W'(MAX_FRAME_BITS)) begin
                        next_q.bit_cnt = q.bit_cnt + 1'b1;
                    end
                end
                if (q.sclk_d && !sclk) begin
                    // from the 32nd bit on the earliest input bits come out again
                    next_q.shift_out = {q.shift_out[WORD_W-2:0], q.shift_in[WORD_W-1]};
                    next_q.sdo = q.shift_out[WORD_W-2];
                end
                if (cs_n) begin
                    next_q.sdo_oe = 1'b0;
                    next_q.state = GSR_DONE;
                end
            end
            GSR_DONE: begin
                if (len_ok(q.bit_cnt)) begin
                    next_q.frame_valid = 1'b1;
                    next_q.frame_word = q.shift_in;
                    frame_ok_dev = q.sent_dev;
                    for (int g = 0; g < 2; g++) begin
                        if (q.zero_seen[g] && q.sent_dev) begin
                            next_q.homing[g] = 1'b0;
                        end
                    end
                end
                next_q.state = GSR_IDLE;
            end
            default: begin
                next_q.state = GSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= '{state: GSR_IDLE, cs_d: 1'b1, sclk_d: 1'b0,
                   sel: SEL_RESET, acc: ACC_RESET, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign sdo_out = q.sdo;
    assign sdo_oe_out = q.sdo_oe;
    assign frame_valid_out = q.frame_valid;
    assign frame_word_out = q.frame_word;
    assign coil_disable_out = q.coil_dis;
    assign gauge_disable_out = q.gauge_dis;
    assign status_select_field_out = q.sel;
endmodule
`default_nettype wire

/* File: tb/gsr_readback_chk.sv */
// assertions on the readback block ports
`timescale 1ns/1ps
`default_nettype none
module gsr_readback_chk
    import gsr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // watched ports
    input wire logic cs_n_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic frame_valid_out,
    input wire logic cfg_write_in,
    input wire logic [WORD_W-1:0] cfg_data_in,
    input wire logic [1:0] gauge_direction_in,
    input wire logic supply_high_in,
    input wire logic [1:0] gauge_hot_in,
    input wire logic coil_disable_out,
    input wire logic [1:0] gauge_disable_out,
    input wire logic [SEL_W-1:0] status_select_field_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    sequence s_cs_low;
        $fell(cs_n_in) ##1 !cs_n_in [*2];
    endsequence
    sequence s_cs_high;
        $rose(cs_n_in) ##1 cs_n_in;
    endsequence
    AST_SEL_HOLD: assert property (!cfg_write_in |=> $stable(status_select_field_out))
        else $error("select moved without a command");
    AST_SEL_LOAD: assert property (cfg_write_in |=> status_select_field_out == $past(cfg_data_in[11:8]))
        else $error("select not taken from command");
    AST_OE_ON: assert property (s_cs_low |-> ##[1:3] sdo_oe_out)
        else $error("output not driven after select");
    AST_OE_OFF: assert property (s_cs_high |-> ##[1:4] !sdo_oe_out)
        else $error("output still driven after deselect");
    AST_DEV_MSB: assert property ($rose(sdo_oe_out) && !status_select_field_out[3] |-> sdo_out == gauge_direction_in[1])
        else $error("first bit is not gauge 1 direction");
    AST_VALID_GAP: assert property (frame_valid_out |-> cs_n_in && $past(cs_n_in, 4))
        else $error("frame accepted while selected");
    AST_VALID_PULSE: assert property (frame_valid_out |=> !frame_valid_out)
        else $error("frame accepted twice");
    AST_COIL_OFF: assert property (supply_high_in |-> ##[1:3] coil_disable_out)
        else $error("coils not disabled on overvoltage");
    AST_COIL_CAUSE: assert property ($rose(coil_disable_out) |-> $past(supply_high_in) || $past(supply_high_in, 2) || $past(supply_high_in, 3))
        else $error("coils disabled without overvoltage");
    AST_HOT_OFF: assert property (gauge_hot_in[0] |-> ##[1:3] gauge_disable_out[0])
        else $error("gauge 0 not disabled when hot");
endmodule
bind gsr_readback gsr_readback_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .frame_valid_out(frame_valid_out),
    .cfg_write_in(cfg_write_in), .cfg_data_in(cfg_data_in), .gauge_direction_in(gauge_direction_in),
    .supply_high_in(supply_high_in), .gauge_hot_in(gauge_hot_in), .coil_disable_out(coil_disable_out),
    .gauge_disable_out(gauge_disable_out), .status_select_field_out(status_select_field_out));
`default_nettype wire

/* File: tb/gsr_spi_master.sv */
// serial bus master model
`timescale 1ns/1ps
`default_nettype none
module gsr_spi_master (
    // link pins toward the device
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    // idle: deselected, clock parked low between frames
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end
    // sdo is read late in the high phase, well after the synchronised device moved it
    task automatic xfer(input int n, input logic [15:0] din, output logic [15:0] dout);
        dout = 16'h0000;
        cs_n_out = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            sdi_out = din[15 - i];
            #160 sclk_out = 1'b1;
            #150 dout[15 - i] = sdo_in;
            #10 sclk_out = 1'b0;
        end
        #160 cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule
`default_nettype wire

/* File: tb/gsr_readback_tb.sv */
// self-checking bench for the readback block
`timescale 1ns/1ps
`default_nettype none
module gsr_readback_tb
    import gsr_pkg::*;
;
    typedef struct {logic [3:0] s; logic [1:0] d, z, o; logic c; logic [14:0] a; logic [15:0] e;} gsr_row_s;
    gsr_row_s rows [6] = '{'{4'h0, 2'h2, 2'h1, 2'h3, 1'h0, 15'h0000, 16'h9C00},
        '{4'h7, 2'h1, 2'h2, 2'h0, 1'h1, 15'h0000, 16'h6080},
        '{4'h8, 2'h0, 2'h0, 2'h0, 1'h0, 15'h4ABC, 16'h4ABC},
        '{4'hB, 2'h3, 2'h3, 2'h3, 1'h1, 15'h0123, 16'h0123},
        '{4'h3, 2'h3, 2'h3, 2'h0, 1'h0, 15'h0000, 16'hF000},
        '{4'h9, 2'h0, 2'h0, 2'h0, 1'h0, 15'h7FFF, 16'h7FFF}};
    logic clk_in = 1'b0;
    logic rstn_in, cw, ld, hi, lo, cal, cs_n, sclk, sdi, sdo, oe, fv, cdis;
    logic [1:0] en, dir, zs, ot, stp, hrq, zf, hot, gdis;
    logic [14:0] acc;
    logic [15:0] cd, fw;
    logic [3:0] sel;
    int err_count = 0;
    int cmp_count = 0;
    always #20 clk_in = ~clk_in;
    gsr_spi_master u_m (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo));
    // counter saturation shortened for simulation
    gsr_readback #(.MAX_FRAME_BITS(64)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(oe),
        .frame_valid_out(fv), .frame_word_out(fw), .cfg_write_in(cw), .cfg_data_in(cd),
        .gauge_enable_in(en), .gauge_direction_in(dir), .gauge_zero_side_in(zs),
        .gauge_off_target_in(ot), .gauge_step_in(stp), .gauge_homing_req_in(hrq),
        .gauge_zero_found_in(zf), .stall_integrator_in(acc), .stall_integrator_load_in(ld),
        .supply_high_in(hi), .supply_low_in(lo), .clock_cal_bad_in(cal), .gauge_hot_in(hot),
        .coil_disable_out(cdis), .gauge_disable_out(gdis), .status_select_field_out(sel));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task setsel(input logic [3:0] s);
        cd = {4'h0, s, 8'h00};
        cw = 1'b1;
        cyc(1);
        cw = 1'b0;
        cyc(1);
    endtask
    // inverted expectation goes in as sdi, so echoed input can never look right by accident
    task rd(input logic [15:0] exp, input int n = 16);
        logic [15:0] got, m;
        int k;
        k = 0;
        m = 16'hFFFF << (16 - n);
        u_m.xfer(n, ~exp, got);
        repeat (12) begin
            @(negedge clk_in);
            if (fv === 1'b1) k++;
        end
        chk(16'(k), (n == 16) ? 16'h0001 : 16'h0000);
        if (n == 16) chk(fw, ~exp);
        chk(got & m, exp & m);
    endtask
    initial begin
        {rstn_in, cw, ld, hi, lo, cal, dir, zs, ot, stp, hrq, zf, hot, acc, cd} = '0;
        en = 2'h3;
        cyc(5);
        rstn_in = 1'b1;
        cyc(6);
        foreach (rows[i]) begin
            {dir, zs, ot, cal, acc} = {rows[i].d, rows[i].z, rows[i].o, rows[i].c, rows[i].a};
            // integrator only loads while homing; drop the request before reading
            {hrq, ld} = {2'h1, 1'b1};
            setsel(rows[i].s);
            {hrq, ld} = '0;
            rd(rows[i].e);
            chk(16'(sel), 16'(rows[i].s));
        end
        $display("table rows done");
        {dir, zs, ot, cal} = '0;
        rstn_in = 1'b0;
        cyc(4);
        rstn_in = 1'b1;
        cyc(6);
        chk(16'(sel), 16'h0000);
        setsel(4'h8);
        rd(16'h0000);
        $display("reset test done");
        setsel(4'h0);
        lo = 1'b1;
        stp = 2'h2;
        cyc(1);
        {lo, stp} = '0;
        cyc(3);
        chk(16'(cdis), 16'h0000);
        rd(16'h0160);
        rd(16'h0000);
        hi = 1'b1;
        cyc(1);
        hi = 1'b0;
        cyc(3);
        chk(16'(cdis), 16'h0001);
        rd(16'h0240, 8);
        rd(16'h0240);
        rd(16'h0000);
        en = 2'h0;
        cyc(2);
        en = 2'h3;
        cyc(2);
        chk(16'(cdis), 16'h0000);
        $display("supply flags done");
        hot = 2'h1;
        cyc(1);
        hot = 2'h0;
        cyc(3);
        chk(16'(gdis), 16'h0001);
        rd(16'h0001);
        rd(16'h0001);
        en = 2'h2;
        cyc(2);
        en = 2'h3;
        cyc(2);
        chk(16'(gdis), 16'h0000);
        rd(16'h0000);
        $display("overtemp done");
        hrq = 2'h1;
        cyc(2);
        rd(16'h0004);
        setsel(4'h8);
        rd(16'h8000);
        zf = 2'h1;
        cyc(1);
        zf = 2'h0;
        setsel(4'h0);
        rd(16'h0004);
        rd(16'h0000);
        setsel(4'h8);
        rd(16'h0000);
        hrq = 2'h2;
        cyc(2);
        rd(16'h8000);
        hrq = 2'h0;
        cyc(2);
        rd(16'h0000);
        $display("homing done");
        close_out();
    end
endmodule
`default_nettype wire
